/* core/vfc_pkg.sv */
package vfc_pkg;
    // register indices on the serial control port
    localparam logic [2:0] ADDR_FILE_COMMAND = 3'h0;
    localparam logic [2:0] ADDR_FILE_CONTROL = 3'h1;
    localparam logic [2:0] ADDR_FILE_DATA    = 3'h2;
    localparam logic [2:0] ADDR_FILE_POINTER = 3'h3;
    localparam logic [2:0] ADDR_STATUS_FLAGS = 3'h4;
    localparam logic [2:0] ADDR_CHIP_CONFIG  = 3'h5;

    // file_command fields
    localparam int CMD_CODE_LSB    = 0;
    localparam int CMD_CONFIRM_BIT = 5;
    localparam int CMD_RESERVE_BIT = 6;

    // file_control fields
    localparam int CTL_SPACE_BIT = 0;
    localparam int CTL_KIND_BIT  = 1;
    localparam int CTL_STAMP_BIT = 2;
    localparam int CTL_USER_BIT  = 3;
    localparam int CTL_FNO_LSB   = 8;

    // chip_config fields
    localparam int CFG_TYPE_LSB = 0;
    localparam int CFG_QUAL_BIT = 2;
    localparam int CFG_SCAN_BIT = 3;

    // status_flags fields
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_ERR_BIT  = 1;
    localparam int ST_PQE_BIT  = 2;
    localparam int ST_FULL_BIT = 3;

    // descriptor user word fields
    localparam int UW_DEL_BIT   = 15;
    localparam int UW_TYPE_BIT  = 14;
    localparam int UW_EXIST_BIT = 13;
    localparam int UW_USER_W    = 12;

    localparam logic [15:0] RST_WORD        = 16'h0000;
    localparam logic [7:0]  MSG_FILES       = 8'hFF;
    localparam logic [7:0]  PROMPT_FILES    = 8'hFE;
    localparam logic [7:0]  PHRASE_FILE     = 8'hFF;
    localparam int          PHRASE_SEL_W    = 11;
    localparam logic [15:0] MAX_UNITS       = 16'hFFFF;
    localparam logic [15:0] BACKUP_BLOCKS   = 16'h0004;
    localparam logic [7:0]  MAX_BAD_BLOCKS  = 8'h37;
    localparam logic [1:0]  MEM_FLASH       = 2'h1;

    localparam int BUSY_MAX_NS  = 150000;
    localparam int CLK_NS       = 40;
    localparam int BUSY_MAX_CYC = BUSY_MAX_NS / CLK_NS;
    localparam int FIFO_DEPTH   = 4;
    localparam int WORD_W       = 16;

    typedef enum logic [4:0] {
        CMD_INIT      = 5'h01,
        CMD_OPEN      = 5'h02,
        CMD_READ_USER = 5'h03,
        CMD_DELETE    = 5'h04,
        CMD_COMPRESS  = 5'h05,
        CMD_GARBAGE   = 5'h06,
        CMD_ABORT     = 5'h07
    } vfc_cmd_e;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_EXEC  = 3'b001,
        ST_SWEEP = 3'b010,
        ST_LONG  = 3'b011,
        ST_DONE  = 3'b100
    } vfc_state_e;
endpackage

/* core/vfc_fifo.sv */
`timescale 1ns/1ps
module vfc_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 4
) (
    input  wire logic             clk_i,
    input  wire logic             rst_n_i,
    input  wire logic [WIDTH-1:0] in_data_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    output logic      [WIDTH-1:0] out_data_o,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_q;
    logic [AW-1:0]    rd_q;
    logic [AW:0]      cnt_q;
    logic             push;
    logic             pop;

    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;
    assign in_ready_o  = (cnt_q < (AW+1)'(DEPTH));
    assign out_valid_o = (cnt_q != '0);
    assign out_data_o  = mem_q[rd_q];

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem_q[wr_q] <= in_data_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
            end
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule // vfc_fifo

/* core/vfc_engine.sv */
// Operation
// - message directory holds 255 descriptors, one per file in message memory.
// - prompt directory holds 254 descriptors; file 255 selects up to 2048 phrases.
// - volatile memory directories are rebuilt after power loss, cleared to zero.
// - non-volatile memory keeps existing descriptors unchanged across reset.
// - a file holds at most 65535 units, words in binary or 30 ms audio.
// - open parameters hold until next open; opening file 0 closes all files.
// - busy is set within 150 us of a command write, 250 us with speakerphone.
// - only compress and garbage collection can be aborted.
// - status shows busy, error and phrase queue empty.
// - writing a valid command code clears the error bit.
// - parameters written only while idle; they act after an open completes.
// - coder and decoder accesses advance the file pointer automatically.
// - user word: 12 host bits, reserved bit, then exists, type, delete on top.
// - device keeps the delete mark, the type bit and the exists bit.
// - initialize needs its 5-bit code plus the confirmation bit set.
// - flash initialize builds both directories, optionally reserving 4 kB.
// - DRAM initialize builds message directory; file number picks deletion start.
// - prompt scan bit scans for a prompt directory, error if none found.
// - initialize returns usable read/write memory in 1 kByte blocks.
// - initialize errors on no memory, over 55 bad blocks, bad wiring.
`timescale 1ns/1ps
module vfc_engine #(
    parameter int LONG_OP_CYCLES = 64
) (
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    input  wire logic [2:0]  reg_addr_i,
    input  wire logic [15:0] reg_wdata_i,
    output logic      [15:0] reg_rdata_o,
    input  wire logic        codec_active_i,
    input  wire logic        codec_unit_i,
    input  wire logic        phrase_queue_empty_i,
    input  wire logic        mem_present_i,
    input  wire logic        mem_wiring_ok_i,
    input  wire logic        prompt_dir_found_i,
    input  wire logic [7:0]  mem_bad_blocks_i,
    input  wire logic [15:0] mem_blocks_i,
    output logic      [15:0] mem_wdata_o,
    output logic             mem_wvalid_o,
    input  wire logic        mem_wready_i,
    output logic             backup_reserved_o
);
    import vfc_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // registers

    logic [15:0] file_command_q;
    logic [15:0] file_control_q;
    logic [15:0] file_data_q;
    logic [15:0] file_pointer_q;
    logic [15:0] chip_config_q;
    logic        cmd_running_q;
    logic        error_q;
    logic        pqe_q;
    logic        full_q;
    vfc_state_e  state_q;
    logic [15:0] op_cnt_q;
    logic [8:0]  sweep_q;
    logic [8:0]  sweep_end_q;
    logic        sweep_gc_q;
    logic        open_q;
    logic        act_space_q;
    logic        act_kind_q;
    logic [7:0]  act_fno_q;
    logic [15:0] rdata_q;
    logic [15:0] dir_q [512];

    logic        wr_cmd;
    logic        wr_ctl;
    logic        wr_data;
    logic        wr_ptr;
    logic        wr_cfg;
    logic [4:0]  code;
    logic        code_ok;
    logic [8:0]  act_idx;
    logic [7:0]  ctl_fno;
    logic        fifo_ready;
    logic        fifo_push;
    logic [15:0] fifo_dout;
    logic        fifo_valid;
    logic        unit_step;

    assign wr_cmd  = reg_wr_i && (reg_addr_i == ADDR_FILE_COMMAND);
    assign wr_ctl  = reg_wr_i && (reg_addr_i == ADDR_FILE_CONTROL);
    assign wr_data = reg_wr_i && (reg_addr_i == ADDR_FILE_DATA);
    assign wr_ptr  = reg_wr_i && (reg_addr_i == ADDR_FILE_POINTER);
    assign wr_cfg  = reg_wr_i && (reg_addr_i == ADDR_CHIP_CONFIG);
    assign code    = reg_wdata_i[CMD_CODE_LSB +: 5];
    assign act_idx = {act_space_q, act_fno_q};
    assign ctl_fno = file_control_q[CTL_FNO_LSB +: 8];

    // initialize is only valid with its confirmation bit
    always_comb begin
        case (code)
            CMD_INIT:      code_ok = reg_wdata_i[CMD_CONFIRM_BIT];
            CMD_OPEN,
            CMD_READ_USER,
            CMD_DELETE,
            CMD_COMPRESS,
            CMD_GARBAGE:   code_ok = 1'b1;
            default:       code_ok = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // host-written parameters

    // parameter writes during a running command are dropped
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            file_control_q <= RST_WORD;
            chip_config_q  <= RST_WORD;
        end else begin
            if (wr_ctl && !cmd_running_q) begin
                file_control_q <= reg_wdata_i;
            end
            if (wr_cfg && !cmd_running_q) begin
                chip_config_q <= reg_wdata_i;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            file_command_q <= RST_WORD;
        end else if (wr_cmd && !cmd_running_q) begin
            file_command_q <= reg_wdata_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // command sequencer

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            state_q       <= ST_IDLE;
            cmd_running_q <= 1'b0;
            error_q       <= 1'b0;
            op_cnt_q      <= '0;
            sweep_q       <= '0;
            sweep_end_q   <= '0;
            sweep_gc_q    <= 1'b0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (wr_cmd && code_ok) begin
                        error_q       <= 1'b0;
                        cmd_running_q <= 1'b1;
                        state_q       <= ST_EXEC;
                    end else if (wr_cmd) begin
                        error_q <= 1'b1;
                    end
                end
                ST_EXEC: begin
                    case (file_command_q[CMD_CODE_LSB +: 5])
                        CMD_INIT: begin
                            // descriptors cleared to zero on build
                            sweep_gc_q <= 1'b0;
                            if (chip_config_q[CFG_TYPE_LSB +: 2]
                                == MEM_FLASH) begin
                                sweep_q     <= 9'h001;
                                sweep_end_q <= 9'h1FF;
                            end else begin
                                // only message space; start at file n
                                sweep_q     <= {1'b0, ctl_fno};
                                sweep_end_q <= (ctl_fno == 8'h00)
                                             ? 9'h000 : 9'h0FF;
                            end
                            state_q <= ST_SWEEP;
                        end
                        CMD_COMPRESS: begin
                            op_cnt_q <= 16'(LONG_OP_CYCLES);
                            state_q  <= ST_LONG;
                        end
                        CMD_GARBAGE: begin
                            sweep_gc_q  <= 1'b1;
                            sweep_q     <= 9'h001;
                            sweep_end_q <= 9'h0FF;
                            state_q     <= ST_SWEEP;
                        end
                        default: begin
                            state_q <= ST_DONE;
                        end
                    endcase
                end
                ST_SWEEP: begin
                    if (sweep_gc_q && wr_cmd && code == CMD_ABORT) begin
                        error_q       <= 1'b1;
                        cmd_running_q <= 1'b0;
                        state_q       <= ST_IDLE;
                    end else if (sweep_q == 9'h000
                                 || sweep_q >= sweep_end_q) begin
                        state_q <= ST_DONE;
                    end else begin
                        sweep_q <= sweep_q + 9'h001;
                    end
                end
                ST_LONG: begin
                    if (wr_cmd && code == CMD_ABORT) begin
                        error_q       <= 1'b1;
                        cmd_running_q <= 1'b0;
                        state_q       <= ST_IDLE;
                    end else if (op_cnt_q == 16'h0000) begin
                        state_q <= ST_DONE;
                    end else begin
                        op_cnt_q <= op_cnt_q - 16'h0001;
                    end
                end
                ST_DONE: begin
                    cmd_running_q <= 1'b0;
                    if (file_command_q[CMD_CODE_LSB +: 5] == CMD_INIT) begin
                        error_q <= !mem_present_i
                                 || (mem_bad_blocks_i > MAX_BAD_BLOCKS)
                                 || !mem_wiring_ok_i
                                 || (chip_config_q[CFG_SCAN_BIT]
                                     && !prompt_dir_found_i);
                    end
                    state_q <= ST_IDLE;
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // active file and pointer

    // message space has 255 files, prompt space 254 plus the phrase file
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            open_q      <= 1'b0;
            act_space_q <= 1'b0;
            act_kind_q  <= 1'b0;
            act_fno_q   <= 8'h00;
        end else if (state_q == ST_EXEC
                     && file_command_q[CMD_CODE_LSB +: 5] == CMD_OPEN) begin
            act_space_q <= file_control_q[CTL_SPACE_BIT];
            act_kind_q  <= file_control_q[CTL_KIND_BIT];
            act_fno_q   <= ctl_fno;
            open_q      <= (ctl_fno != 8'h00);
        end else if (state_q == ST_EXEC
                     && file_command_q[CMD_CODE_LSB +: 5] == CMD_INIT) begin
            open_q <= 1'b0;
        end
    end

    assign unit_step = open_q && (codec_unit_i || fifo_push);

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            file_pointer_q <= RST_WORD;
        end else if (state_q == ST_EXEC
                     && file_command_q[CMD_CODE_LSB +: 5] == CMD_OPEN) begin
            file_pointer_q <= RST_WORD;
        end else if (wr_ptr && !cmd_running_q) begin
            if (act_space_q && act_fno_q == PHRASE_FILE) begin
                // phrase selector: 2048 phrases
                file_pointer_q <= {5'h00,
                    reg_wdata_i[PHRASE_SEL_W-1:0]};
            end else begin
                file_pointer_q <= reg_wdata_i;
            end
        end else if (unit_step && file_pointer_q != MAX_UNITS) begin
            file_pointer_q <= file_pointer_q + 16'h0001;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // descriptor user words

    always_ff @(posedge clk_i) begin
        if (state_q == ST_SWEEP && sweep_q != 9'h000) begin
            if (!sweep_gc_q || dir_q[sweep_q][UW_DEL_BIT]) begin
                dir_q[sweep_q] <= RST_WORD;
            end
        end else if (state_q == ST_EXEC && open_q == 1'b0
                     && file_command_q[CMD_CODE_LSB +: 5] == CMD_OPEN
                     && ctl_fno != 8'h00
                     && !file_control_q[CTL_SPACE_BIT]) begin
            // host bits plus the type bit from the open's kind; delete and exists bits stay device owned
            dir_q[{1'b0, ctl_fno}][UW_TYPE_BIT] <=
                file_control_q[CTL_KIND_BIT];
            if (file_control_q[CTL_USER_BIT]) begin
                dir_q[{1'b0, ctl_fno}][UW_USER_W-1:0] <=
                    file_data_q[UW_USER_W-1:0];
            end
        end else if (state_q == ST_EXEC && open_q
                     && file_command_q[CMD_CODE_LSB +: 5] == CMD_DELETE) begin
            dir_q[act_idx][UW_DEL_BIT] <= 1'b1;
        end else if (unit_step && !act_space_q) begin
            dir_q[act_idx][UW_EXIST_BIT] <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // data register and write buffer

    // binary words head for memory through the buffer; when it is full
    // the word is refused and flagged rather than silently overwritten
    assign fifo_push = wr_data && open_q && !act_kind_q && fifo_ready
                       && !cmd_running_q;

    vfc_fifo #(
        .WIDTH (WORD_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_i       (clk_i),
        .rst_n_i     (rst_n_i),
        .in_data_i   (reg_wdata_i),
        .in_valid_i  (fifo_push),
        .in_ready_o  (fifo_ready),
        .out_data_o  (fifo_dout),
        .out_valid_o (fifo_valid),
        .out_ready_i (mem_wready_i)
    );

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            mem_wdata_o  <= RST_WORD;
            mem_wvalid_o <= 1'b0;
        end else begin
            mem_wdata_o  <= fifo_dout;
            mem_wvalid_o <= fifo_valid;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            file_data_q <= RST_WORD;
        end else if (state_q == ST_DONE
                     && file_command_q[CMD_CODE_LSB +: 5] == CMD_INIT) begin
            // usable blocks, less the 4 backup blocks when reserved
            file_data_q <= (file_command_q[CMD_RESERVE_BIT]
                            && mem_blocks_i >= BACKUP_BLOCKS)
                         ? mem_blocks_i - BACKUP_BLOCKS
                         : mem_blocks_i;
        end else if (state_q == ST_EXEC
                     && file_command_q[CMD_CODE_LSB +: 5]
                        == CMD_READ_USER) begin
            file_data_q <= dir_q[{file_control_q[CTL_SPACE_BIT], ctl_fno}];
        end else if (wr_data && !cmd_running_q) begin
            file_data_q <= reg_wdata_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            backup_reserved_o <= 1'b0;
        end else if (state_q == ST_DONE
                     && file_command_q[CMD_CODE_LSB +: 5] == CMD_INIT
                     && chip_config_q[CFG_TYPE_LSB +: 2] == MEM_FLASH) begin
            backup_reserved_o <= file_command_q[CMD_RESERVE_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // status and readback

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            pqe_q  <= 1'b1;
            full_q <= 1'b0;
        end else begin
            pqe_q  <= phrase_queue_empty_i;
            full_q <= !fifo_ready;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            rdata_q <= RST_WORD;
        end else if (reg_rd_i) begin
            case (reg_addr_i)
                ADDR_FILE_COMMAND: rdata_q <= file_command_q;
                ADDR_FILE_CONTROL: rdata_q <= file_control_q;
                ADDR_FILE_DATA:    rdata_q <= file_data_q;
                ADDR_FILE_POINTER: rdata_q <= file_pointer_q;
                ADDR_CHIP_CONFIG:  rdata_q <= chip_config_q;
                ADDR_STATUS_FLAGS: begin
                    rdata_q              <= RST_WORD;
                    rdata_q[ST_BUSY_BIT] <= cmd_running_q
                                            || codec_active_i;
                    rdata_q[ST_ERR_BIT]  <= error_q;
                    rdata_q[ST_PQE_BIT]  <= pqe_q;
                    rdata_q[ST_FULL_BIT] <= full_q;
                end
                default:           rdata_q <= RST_WORD;
            endcase
        end
    end

    assign reg_rdata_o = rdata_q;
endmodule // vfc_engine

/* tb/vfc_engine_assertions.sv */
`timescale 1ns/1ps
module vfc_engine_checker
    import vfc_pkg::*;
(
    input wire logic        clk_i,
    input wire logic        rst_n_i,
    input wire logic        reg_wr_i,
    input wire logic        reg_rd_i,
    input wire logic [2:0]  reg_addr_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic [15:0] reg_rdata_o,
    input wire logic        codec_active_i,
    input wire logic        phrase_queue_empty_i,
    input wire logic        mem_wvalid_o,
    input wire logic        mem_wready_i,
    input wire logic        backup_reserved_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    ////////////////////////////////////////////////////////////////////
    sequence s_rd_st;
        reg_rd_i && reg_addr_i == ADDR_STATUS_FLAGS;
    endsequence
    sequence s_open;
        reg_wr_i && reg_addr_i == ADDR_FILE_COMMAND
            && reg_wdata_i[4:0] == CMD_OPEN;
    endsequence
    a_cmd_sets_busy: assert property (s_open ##1 s_rd_st |=>
        reg_rdata_o[ST_BUSY_BIT]) else $error("busy not set after command");
    a_cmd_clears_err: assert property (s_open ##1 s_rd_st |=>
        !reg_rdata_o[ST_ERR_BIT]) else $error("error kept after command");
    a_pqe_high_seen: assert property (phrase_queue_empty_i[*3] ##0
        s_rd_st |=> reg_rdata_o[ST_PQE_BIT]) else $error("queue empty lost");
    a_pqe_low_seen: assert property (!phrase_queue_empty_i[*3] ##0
        s_rd_st |=> !reg_rdata_o[ST_PQE_BIT]) else $error("queue empty stuck");
    a_codec_shows_busy: assert property (codec_active_i[*2] ##0
        s_rd_st |=> reg_rdata_o[ST_BUSY_BIT]) else $error("codec busy lost");
    a_rdata_holds: assert property (!$past(reg_rd_i) |->
        $stable(reg_rdata_o)) else $error("read data moved without read");
    a_unmapped_zero: assert property (reg_rd_i
        && reg_addr_i > ADDR_CHIP_CONFIG |=> reg_rdata_o == RST_WORD)
        else $error("unmapped index read nonzero");
    a_wvalid_holds: assert property (!mem_wready_i[*3] ##0 mem_wvalid_o
        |=> mem_wvalid_o) else $error("buffered word dropped while stalled");
    a_reset_quiet: assert property ($rose(rst_n_i) |-> !mem_wvalid_o
        && !backup_reserved_o && reg_rdata_o == RST_WORD)
        else $error("outputs active after reset");
endmodule // vfc_engine_checker

bind vfc_engine vfc_engine_checker i_vfc_engine_checker (
    .clk_i, .rst_n_i, .reg_wr_i, .reg_rd_i, .reg_addr_i, .reg_wdata_i,
    .reg_rdata_o, .codec_active_i, .phrase_queue_empty_i, .mem_wvalid_o,
    .mem_wready_i, .backup_reserved_o);

/* tb/vfc_mem_sink.sv */
`timescale 1ns/1ps
module vfc_mem_sink (
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        stall_i,
    input  wire logic        valid_i,
    input  wire logic [15:0] data_i,
    output logic             ready_o
);
    logic [1:0]  gap_q;
    logic [15:0] got[$];
    // one word per pulse, then a gap so the lagging valid catches up
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            ready_o <= 1'b0;
            gap_q   <= 2'h0;
        end else if (ready_o) begin
            ready_o <= 1'b0;
            gap_q   <= 2'h3;
        end else if (gap_q != 2'h0) begin
            gap_q <= gap_q - 2'h1;
        end else if (valid_i && !stall_i) begin
            ready_o <= 1'b1;
        end
    end
    always @(posedge clk_i) begin
        if (rst_n_i && ready_o && valid_i) begin
            got.push_back(data_i);
        end
    end
endmodule // vfc_mem_sink

/* tb/vfc_engine_test.sv */
`timescale 1ns/1ps
module vfc_engine_test;
    import vfc_pkg::*;
    logic clk_i = 0, rst_n_i = 0, reg_wr_i = 0, reg_rd_i = 0, stall = 0;
    logic codec_active_i = 0, codec_unit_i = 0, phrase_queue_empty_i = 1;
    logic mem_present_i = 1, mem_wiring_ok_i = 1, prompt_dir_found_i = 0;
    logic mem_wvalid_o, mem_wready_i, backup_reserved_o, sc;
    logic [2:0]  reg_addr_i = 0;
    logic [7:0]  mem_bad_blocks_i = 0, bb, fno;
    logic [15:0] reg_wdata_i = 0, mem_blocks_i = 0, reg_rdata_o;
    logic [15:0] mem_wdata_o, d, w, sent[$];
    logic [2:0]  zl[5] = '{ADDR_FILE_CONTROL, ADDR_FILE_DATA,
                          ADDR_FILE_POINTER, 3'h6, 3'h7};
    int seed = 86003, bad_count = 0, checks = 0;
    vfc_engine #(.LONG_OP_CYCLES(4)) i_vfc_engine (.*);
    vfc_mem_sink i_vfc_mem_sink (.clk_i, .rst_n_i, .stall_i(stall),
        .valid_i(mem_wvalid_o), .data_i(mem_wdata_o), .ready_o(mem_wready_i));
    initial begin
        forever #20 clk_i = ~clk_i;
    end
    ////////////////////////////////////////////////////////////////////
    task automatic chk(string n, logic [15:0] e, logic [15:0] g);
        checks++;
        if (e !== g) begin
            bad_count++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic end_sim;
        $display("checks %0d errors %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic wr(logic [2:0] a, logic [15:0] v);
        if (reg_wr_i) @(posedge clk_i);
        reg_addr_i  <= a;
        reg_wdata_i <= v;
        reg_wr_i    <= 1'b1;
        @(posedge clk_i);
        reg_wr_i <= 1'b0;
    endtask
    task automatic rd(logic [2:0] a, output logic [15:0] v);
        reg_addr_i <= a;
        reg_rd_i   <= 1'b1;
        @(posedge clk_i);
        reg_rd_i <= 1'b0;
        @(posedge clk_i);
        v = reg_rdata_o;
    endtask
    // leaves the last status word in d
    task automatic wait_idle;
        for (int i = 0; i < 1500; i++) begin
            rd(ADDR_STATUS_FLAGS, d);
            if (d[ST_BUSY_BIT] === 1'b0) return;
        end
        chk("idle", 16'h0000, 16'hFFFF);
    endtask
    function automatic logic init_err(logic [7:0] b, logic s, logic f);
        return b > MAX_BAD_BLOCKS || (s && !f);
    endfunction
    ////////////////////////////////////////////////////////////////////
    initial begin
        #(40 * 20000);
        bad_count++;
        end_sim;
    end
    initial begin
        repeat (8) @(posedge clk_i);
        rst_n_i <= 1'b1;
        foreach (zl[i]) begin
            rd(zl[i], d);
            chk("reset word", RST_WORD, d);
        end
        // the good case runs last so later opens find usable memory
        for (int i = 2; i >= 0; i--) begin
            sc = (i == 2);
            bb = (i == 1) ? 8'h38 : 8'({$random(seed)} % 56);
            mem_bad_blocks_i <= bb;
            mem_blocks_i <= $random(seed);
            wr(ADDR_CHIP_CONFIG, {12'h000, sc, 1'b0, MEM_FLASH});
            wr(ADDR_FILE_COMMAND, 16'h0061);
            wr(ADDR_FILE_CONTROL, 16'hABCD);
            wait_idle;
            chk("init err", 16'(init_err(bb, sc, 1'b0)), 16'(d[1]));
            rd(ADDR_FILE_CONTROL, d);
            chk("ctl busy", RST_WORD, d);
        end
        rd(ADDR_FILE_DATA, d);
        chk("blocks", mem_blocks_i - (mem_blocks_i < BACKUP_BLOCKS ?
            16'h0000 : BACKUP_BLOCKS), d);
        chk("backup", 16'h0001, 16'(backup_reserved_o));
        wr(ADDR_FILE_COMMAND, 16'h001F);
        wait_idle;
        chk("bad code", 16'h0002, {14'h0, d[1:0]});
        fno = 8'({$random(seed)} % 254 + 1);
        wr(ADDR_FILE_CONTROL, {fno, 8'h00});
        wr(ADDR_FILE_COMMAND, {11'h000, CMD_OPEN});
        wait_idle;
        chk("open", 16'h0000, {14'h0, d[1:0]});
        rd(ADDR_FILE_POINTER, d);
        chk("ptr open", RST_WORD, d);
        stall <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            w = $random(seed);
            wr(ADDR_FILE_DATA, w);
            if (i < FIFO_DEPTH) sent.push_back(w);
        end
        rd(ADDR_STATUS_FLAGS, d);
        chk("full", 16'h0001, 16'(d[ST_FULL_BIT]));
        rd(ADDR_FILE_POINTER, d);
        chk("ptr push", 16'h0004, d);
        stall <= 1'b0;
        for (int i = 0; i < 200 && i_vfc_mem_sink.got.size() < 4; i++)
            @(posedge clk_i);
        chk("count", 16'h0004, 16'(i_vfc_mem_sink.got.size()));
        foreach (sent[i]) chk("word", sent[i], i_vfc_mem_sink.got[i]);
        codec_active_i <= 1'b1;
        phrase_queue_empty_i <= 1'b0;
        repeat (3) begin
            codec_unit_i <= 1'b1;
            @(posedge clk_i);
            codec_unit_i <= 1'b0;
            @(posedge clk_i);
        end
        rd(ADDR_STATUS_FLAGS, d);
        chk("codec st", 16'h0001, {13'h0, d[3:2], d[0]});
        codec_active_i <= 1'b0;
        phrase_queue_empty_i <= 1'b1;
        rd(ADDR_FILE_POINTER, d);
        chk("ptr codec", 16'h0007, d);
        wr(ADDR_FILE_COMMAND, {11'h000, CMD_READ_USER});
        wait_idle;
        rd(ADDR_FILE_DATA, d);
        chk("user word", 16'h2000, d);
        wr(ADDR_FILE_COMMAND, {11'h000, CMD_COMPRESS});
        wr(ADDR_FILE_COMMAND, {11'h000, CMD_ABORT});
        wait_idle;
        chk("abort", 16'h0001, 16'(d[ST_ERR_BIT]));
        end_sim;
    end
endmodule // vfc_engine_test
